// >>> hdl/efc_pkg.sv
// constants shared by the ethernet control and flow control block
package efc_pkg;
	localparam int EFC_ADDR_W = 8;
	localparam logic [1:0] EFC_BLK_CON1 = 2'h0;
	localparam logic [1:0] EFC_BLK_CON2 = 2'h1;
	localparam logic [1:0] EFC_BLK_WM = 2'h2;
	localparam logic [1:0] EFC_BLK_STAT = 2'h3;
	localparam logic [1:0] EFC_OP_WRITE = 2'h0;
	localparam logic [1:0] EFC_OP_CLR = 2'h1;
	localparam logic [1:0] EFC_OP_SET = 2'h2;
	localparam logic [1:0] EFC_OP_INV = 2'h3;
	localparam logic [2:0] EFC_SEL_CON1 = 3'h0;
	localparam logic [2:0] EFC_SEL_CON2 = 3'h1;
	localparam logic [2:0] EFC_SEL_WM = 3'h2;
	localparam logic [2:0] EFC_SEL_STAT = 3'h3;
	localparam logic [2:0] EFC_SEL_NONE = 3'h4;
	localparam int EFC_PTV_LSB = 16;
	localparam int EFC_ON_BIT = 15;
	localparam int EFC_IDLE_STOP_BIT = 13;
	localparam int EFC_TRANSMIT_REQUEST_BIT = 9;
	localparam int EFC_RECEIVE_ENABLE_BIT = 8;
	localparam int EFC_AUTO_FLOW_CTL_BIT = 7;
	localparam int EFC_MANUAL_FLOW_CTL_BIT = 4;
	localparam int EFC_BUFFER_COUNT_DECREMENT_BIT = 0;
	localparam int EFC_BUFSZ_LSB = 4;
	localparam int EFC_BUFSZ_MSB = 10;
	localparam int EFC_WM_FULL_LSB = 0;
	localparam int EFC_WM_EMPTY_LSB = 8;
	localparam int EFC_STAT_CNT_LSB = 16;
	localparam int EFC_STAT_TXBUSY_BIT = 0;
	localparam int EFC_STAT_PAUSE_BIT = 1;
	localparam logic [31:0] EFC_CON1_MASK = 32'hFFFF_A390;
	localparam logic [31:0] EFC_CON2_MASK = 32'h0000_07F0;
	localparam logic [31:0] EFC_WM_MASK = 32'h0000_FFFF;
	localparam logic [31:0] EFC_CON1_RESET = 32'h0000_0000;
	localparam logic [31:0] EFC_CON2_RESET = 32'h0000_0000;
	localparam logic [31:0] EFC_WM_RESET = 32'h0000_0410;
	localparam int EFC_PAUSE_SHIFT = 6;
	localparam int EFC_BYTE_SHIFT = 4;
	localparam logic [1:0] EFC_RESP_OKAY = 2'h0;
	localparam logic [1:0] EFC_RESP_SLVERR = 2'h2;
endpackage : efc_pkg

// >>> hdl/efc_pause_timer.sv
// pause resend interval counter, counting tx clock rising edges
`timescale 1ns/1ns
module efc_pause_timer #(
	parameter int CNT_W = 22
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic load,
	input wire logic stop,
	input wire logic [CNT_W-1:0] load_value,
	output logic expired
);
	logic [CNT_W-1:0] cnt;
	logic armed;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= '0;
			armed <= 1'b0;
		end else if (stop) begin
			armed <= 1'b0;
		end else if (load) begin
			cnt <= load_value;
			armed <= 1'b1;
		end else if (armed && tick && cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			expired <= 1'b0;
		end else begin
			expired <= armed && !load && !stop && cnt == '0;
		end
	end
endmodule : efc_pause_timer

// >>> hdl/efc_ctrl.sv
// ethernet controller enable, transmit request, receive enable and flow control
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
module efc_ctrl import efc_pkg::*; #(
	parameter int CNT_W = 8,
	parameter int PTV_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [EFC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [EFC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic idle_mode,
	input wire logic tx_clk,
	output logic tx_pkt_req,
	input wire logic tx_pkt_ack,
	input wire logic tx_pkt_done,
	input wire logic tx_table_end,
	output logic rx_enable,
	input wire logic rx_pkt_stored,
	output logic [EFC_BUFSZ_MSB:0] rx_buf_bytes,
	output logic flow_ctl_active,
	output logic pause_req,
	output logic [PTV_W-1:0] pause_value,
	input wire logic pause_sent
);
	typedef enum logic [1:0] {EFC_FC_IDLE, EFC_FC_SEND, EFC_FC_WAIT, EFC_FC_SEND_ZERO} efc_fc_state_t;

	function automatic logic [2:0] efc_decode(input logic [EFC_ADDR_W-1:0] addr);
		logic [2:0] sel;
		sel = EFC_SEL_NONE;
		if (addr[EFC_ADDR_W-1:6] == '0) begin
			unique case (addr[5:4])
				EFC_BLK_CON1: sel = EFC_SEL_CON1;
				EFC_BLK_CON2: sel = EFC_SEL_CON2;
				EFC_BLK_WM: sel = EFC_SEL_WM;
				EFC_BLK_STAT: sel = (addr[3:2] == EFC_OP_WRITE) ? EFC_SEL_STAT : EFC_SEL_NONE;
			endcase
		end
		return sel;
	endfunction : efc_decode

	function automatic logic [31:0] efc_apply(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [1:0] op, input logic [31:0] mask);
		logic [31:0] m;
		logic [31:0] v;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		unique case (op)
			EFC_OP_WRITE: v = (old & ~m) | (wd & m);
			EFC_OP_CLR: v = old & ~(wd & m);
			EFC_OP_SET: v = old | (wd & m);
			EFC_OP_INV: v = old ^ (wd & m);
		endcase
		return v & mask;
	endfunction : efc_apply

	logic [31:0] con1;
	logic [31:0] con2;
	logic [31:0] wm;
	logic [31:0] next_con1;
	logic [CNT_W-1:0] buf_count;
	logic aw_hold;
	logic w_hold;
	logic [EFC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [2:0] wr_sel;
	logic [1:0] wr_op;
	logic [2:0] rd_sel;
	logic [31:0] rd_value;
	logic tx_busy;
	logic tx_finish_all;
	logic paused;
	logic running;
	logic dec_req;
	logic inc_req;
	logic tx_clk_prev;
	logic tx_tick;
	logic timer_load;
	logic timer_stop;
	logic timer_expired;
	efc_fc_state_t fc_state;
	logic [CNT_W-1:0] wm_full;
	logic [CNT_W-1:0] wm_empty;

	assign running = con1[EFC_ON_BIT];
	assign paused = con1[EFC_IDLE_STOP_BIT] && idle_mode;
	assign wm_full = wm[EFC_WM_FULL_LSB +: CNT_W];
	assign wm_empty = wm[EFC_WM_EMPTY_LSB +: CNT_W];
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_sel = efc_decode(aw_addr);
	assign wr_op = aw_addr[3:2];
	assign rd_sel = efc_decode(s_axi_araddr);
	assign tx_finish_all = tx_busy && tx_pkt_done && tx_table_end;
	// a clear alias never counts as a write of one to the decrement bit
	assign dec_req = wr_fire && wr_sel == EFC_SEL_CON1 && wr_op != EFC_OP_CLR && w_strb[0]
		&& w_data[EFC_BUFFER_COUNT_DECREMENT_BIT];
	assign inc_req = rx_pkt_stored && rx_enable;
	// tx clock arrives synchronous to aclk, so a plain edge detect is safe
	assign tx_tick = tx_clk && !tx_clk_prev;

	always_comb begin
		next_con1 = con1;
		if (tx_finish_all) begin
			next_con1[EFC_TRANSMIT_REQUEST_BIT] = 1'b0;
		end
		// software write is applied on top, so a fresh request wins over the hardware clear
		if (wr_fire && wr_sel == EFC_SEL_CON1) begin
			next_con1 = efc_apply(next_con1, w_data, w_strb, wr_op, EFC_CON1_MASK);
		end
	end

	always_comb begin
		rd_value = 32'h0000_0000;
		unique case (rd_sel)
			EFC_SEL_CON1: rd_value = con1;
			EFC_SEL_CON2: rd_value = con2;
			EFC_SEL_WM: rd_value = wm;
			EFC_SEL_STAT: begin
				rd_value[EFC_STAT_CNT_LSB +: CNT_W] = buf_count;
				rd_value[EFC_STAT_TXBUSY_BIT] = tx_busy;
				rd_value[EFC_STAT_PAUSE_BIT] = fc_state != EFC_FC_IDLE;
			end
			default: rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			con1 <= EFC_CON1_RESET;
		end else begin
			con1 <= next_con1;
		end
	end

	// the size field is trusted to change only while receive is disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			con2 <= EFC_CON2_RESET;
			wm <= EFC_WM_RESET;
		end else if (wr_fire) begin
			if (wr_sel == EFC_SEL_CON2) begin
				con2 <= efc_apply(con2, w_data, w_strb, wr_op, EFC_CON2_MASK);
			end
			if (wr_sel == EFC_SEL_WM) begin
				wm <= efc_apply(wm, w_data, w_strb, wr_op, EFC_WM_MASK);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_hold <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_hold <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= EFC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_sel == EFC_SEL_NONE || wr_sel == EFC_SEL_STAT) ? EFC_RESP_SLVERR : EFC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= EFC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value;
			s_axi_rresp <= (rd_sel == EFC_SEL_NONE) ? EFC_RESP_SLVERR : EFC_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// transmit sequencing: one packet at a time, request dropped while a packet is in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy <= 1'b0;
		end else if (tx_pkt_req && tx_pkt_ack) begin
			tx_busy <= 1'b1;
		end else if (tx_pkt_done) begin
			tx_busy <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_pkt_req <= 1'b0;
		end else if (tx_pkt_req && tx_pkt_ack) begin
			tx_pkt_req <= 1'b0;
		end else begin
			// a cleared request lets the packet in flight finish but starts no other
			tx_pkt_req <= running && !paused && next_con1[EFC_TRANSMIT_REQUEST_BIT] && !tx_busy
				&& !tx_pkt_done;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_enable <= 1'b0;
			rx_buf_bytes <= '0;
		end else begin
			rx_enable <= next_con1[EFC_ON_BIT] && next_con1[EFC_RECEIVE_ENABLE_BIT] && !paused;
			// code 1 gives 16 bytes, all ones gives 2032 bytes; code 0 is left to software
			rx_buf_bytes <= {con2[EFC_BUFSZ_MSB:EFC_BUFSZ_LSB], {EFC_BYTE_SHIFT{1'b0}}};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_count <= '0;
		end else if (inc_req && dec_req) begin
			buf_count <= buf_count;
		end else if (inc_req && buf_count != '1) begin
			buf_count <= buf_count + 1'b1;
		end else if (dec_req && buf_count != '0) begin
			buf_count <= buf_count - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flow_ctl_active <= 1'b0;
		end else if (!running || !con1[EFC_AUTO_FLOW_CTL_BIT]) begin
			flow_ctl_active <= 1'b0;
		end else if (buf_count >= wm_full) begin
			flow_ctl_active <= 1'b1;
		end else if (buf_count <= wm_empty) begin
			flow_ctl_active <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_clk_prev <= 1'b0;
		end else begin
			tx_clk_prev <= tx_clk;
		end
	end

	assign timer_load = fc_state == EFC_FC_SEND && pause_sent;
	assign timer_stop = !running || fc_state == EFC_FC_IDLE || fc_state == EFC_FC_SEND_ZERO;

	efc_pause_timer #(
		.CNT_W(PTV_W + EFC_PAUSE_SHIFT)
	) u_pause_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tx_tick),
		.load(timer_load),
		.stop(timer_stop),
		.load_value({con1[EFC_PTV_LSB +: PTV_W], {EFC_PAUSE_SHIFT{1'b0}}}),
		.expired(timer_expired)
	);

	// pause timer value is sampled at each send; it is meant to be stable while receiving
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fc_state <= EFC_FC_IDLE;
		end else if (!running) begin
			fc_state <= EFC_FC_IDLE;
		end else begin
			unique case (fc_state)
				EFC_FC_IDLE: begin
					if (con1[EFC_MANUAL_FLOW_CTL_BIT]) begin
						fc_state <= EFC_FC_SEND;
					end
				end
				EFC_FC_SEND: begin
					if (pause_sent) begin
						fc_state <= con1[EFC_MANUAL_FLOW_CTL_BIT] ? EFC_FC_WAIT : EFC_FC_SEND_ZERO;
					end
				end
				EFC_FC_WAIT: begin
					if (!con1[EFC_MANUAL_FLOW_CTL_BIT]) begin
						fc_state <= EFC_FC_SEND_ZERO;
					end else if (timer_expired) begin
						fc_state <= EFC_FC_SEND;
					end
				end
				EFC_FC_SEND_ZERO: begin
					if (pause_sent) begin
						fc_state <= EFC_FC_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pause_req <= 1'b0;
			pause_value <= '0;
		end else if (!running || pause_sent) begin
			pause_req <= 1'b0;
		end else if (fc_state == EFC_FC_SEND) begin
			pause_req <= 1'b1;
			pause_value <= con1[EFC_PTV_LSB +: PTV_W];
		end else if (fc_state == EFC_FC_SEND_ZERO) begin
			pause_req <= 1'b1;
			pause_value <= '0;
		end
	end
endmodule : efc_ctrl

// >>> test/efc_ctrl_checker.sv
// port assertions for the ethernet control and flow control block
`timescale 1ns/1ns
module efc_ctrl_checker import efc_pkg::*; #(
	parameter int PTV_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic tx_pkt_req,
	input wire logic tx_pkt_ack,
	input wire logic [EFC_BUFSZ_MSB:0] rx_buf_bytes,
	input wire logic pause_req,
	input wire logic [PTV_W-1:0] pause_value,
	input wire logic pause_sent
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_reopen;
		!s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready);
	endsequence
	sequence s_pause_wait;
		pause_req && !pause_sent;
	endsequence
	a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=> s_reopen)
		else $error("write channel not reopened");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == EFC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read carries data");
	a_size_units: assert property (rx_buf_bytes[3:0] == 4'h0)
		else $error("buffer size not in 16 byte units");
	a_txreq_drop: assert property (tx_pkt_req && tx_pkt_ack |=> !tx_pkt_req)
		else $error("packet request held after ack");
	a_pause_value: assert property (s_pause_wait ##1 pause_req |-> $stable(pause_value))
		else $error("pause value moved while pending");
endmodule : efc_ctrl_checker

bind efc_ctrl efc_ctrl_checker #(.PTV_W(PTV_W)) u_chk (.*);

// >>> test/efc_phy_model.sv
// far side model: transmit engine, pause frame sender, free running tx clock
`timescale 1ns/1ns
module efc_phy_model #(
	parameter int PKTS = 2,
	parameter int PKT_CYC = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tx_pkt_req,
	input wire logic pause_req,
	output logic tx_clk = 1'b0,
	output logic tx_pkt_ack = 1'b0,
	output logic tx_pkt_done = 1'b0,
	output logic tx_table_end = 1'b0,
	output logic pause_sent = 1'b0
);
	int tcnt;
	int sent;
	int pcnt;
	// phy tx clock runs free at the 100 Mbps rate, its rising edges a fixed 2 ns after an aclk rising edge
	initial begin
		#7;
		forever #20 tx_clk = ~tx_clk;
	end
	always @(posedge aclk) begin
		tx_pkt_ack <= 1'b0;
		tx_pkt_done <= 1'b0;
		// end flag means nothing between packets, so it wanders
		tx_table_end <= ~tx_table_end;
		if (!aresetn) begin
			tcnt <= 0;
			sent <= 0;
			tx_table_end <= 1'b0;
		end else if (tcnt > 1) begin
			tcnt <= tcnt - 1;
		end else if (tcnt == 1) begin
			tcnt <= 0;
			tx_pkt_done <= 1'b1;
			tx_table_end <= (sent == PKTS - 1);
			sent <= (sent == PKTS - 1) ? 0 : sent + 1;
		end else if (tx_pkt_req && !tx_pkt_ack) begin
			tx_pkt_ack <= 1'b1;
			tcnt <= PKT_CYC;
		end
	end
	always @(posedge aclk) begin
		pause_sent <= 1'b0;
		if (!aresetn) begin
			pcnt <= 0;
		end else if (pcnt > 1) begin
			pcnt <= pcnt - 1;
		end else if (pcnt == 1) begin
			pcnt <= 0;
			pause_sent <= 1'b1;
		end else if (pause_req && !pause_sent) begin
			pcnt <= 4;
		end
	end
endmodule : efc_phy_model

// >>> test/tb_top.sv
// register level bench for the ethernet control and flow control block
`timescale 1ns/1ns
module tb_top import efc_pkg::*;;
	localparam logic [1:0] OK = EFC_RESP_OKAY;
	localparam logic [1:0] ER = EFC_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic idle_mode = 1'b0, rx_pkt_stored = 1'b0;
	logic tx_clk, tx_pkt_req, tx_pkt_ack, tx_pkt_done, tx_table_end, rx_enable;
	logic flow_ctl_active, pause_req, pause_sent;
	logic [10:0] rx_buf_bytes;
	logic [15:0] pause_value;
	int fail_count = 0;
	int tests_run = 0;
	int dones = 0;
	int edges = 0;
	int mark;
	always #5 aclk = ~aclk;
	always @(posedge tx_clk) edges++;
	always @(posedge aclk) begin
		if (tx_pkt_done === 1'b1)
			dones++;
	end
	efc_ctrl uut (.*);
	efc_phy_model far (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		check(s_axi_bvalid, 1'b1);
		check(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		check(s_axi_rvalid, 1'b1);
		check(s_axi_rdata, ed);
		check(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// waits for a pause request carrying the given value
	task automatic wait_pause(input logic [15:0] v);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(pause_req === 1'b1 && pause_value === v) && n < 3000);
		check(pause_req, 1'b1);
		check(pause_value, v);
	endtask : wait_pause
	task automatic give_verdict;
		if (fail_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00, 32'h0, OK);
		rd(8'h24, 32'h0000_0410, OK);
		rd(8'h40, 32'h0, ER);
		wr(8'h38, 32'h1, ER);
		wr(8'h10, 32'h7F0, OK);
		check(rx_buf_bytes, 32'd2032);
		wr(8'h14, 32'h7E0, OK);
		check(rx_buf_bytes, 32'd16);
		rd(8'h10, 32'h10, OK);
		wr(8'h08, 32'hA100, OK);
		check(rx_enable, 1);
		idle_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		check(rx_enable, 0);
		wr(8'h0C, 32'h2000, OK);
		check(rx_enable, 1);
		idle_mode <= 1'b0;
		wr(8'h04, 32'h8000, OK);
		check(rx_enable, 0);
		rd(8'h00, 32'h100, OK);
		wr(8'h08, 32'h8000, OK);
		wr(8'h20, 32'h0103, OK);
		for (int i = 0; i < 3; i++) begin
			rx_pkt_stored <= 1'b1;
			@(posedge aclk);
			rx_pkt_stored <= 1'b0;
			@(posedge aclk);
		end
		check(flow_ctl_active, 0);
		wr(8'h08, 32'h80, OK);
		repeat (2) @(posedge aclk);
		check(flow_ctl_active, 1);
		rd(8'h30, 32'h0003_0000, OK);
		wr(8'h08, 32'h1, OK);
		rd(8'h00, 32'h8180, OK);
		check(flow_ctl_active, 1);
		wr(8'h00, 32'h8180, OK);
		wr(8'h0C, 32'h1, OK);
		repeat (2) @(posedge aclk);
		check(flow_ctl_active, 0);
		rd(8'h30, 32'h0001_0000, OK);
		// stored pulses cover every edge of the write, so the decrement edge meets an increment
		rx_pkt_stored <= 1'b1;
		wr(8'h08, 32'h1, OK);
		rx_pkt_stored <= 1'b0;
		rd(8'h30, 32'h0004_0000, OK);
		wr(8'h04, 32'h0180, OK);
		wr(8'h08, 32'h0002_0000, OK);
		wr(8'h08, 32'h10, OK);
		wait_pause(16'h2);
		while (pause_sent !== 1'b1)
			@(posedge aclk);
		mark = edges;
		repeat (2) @(posedge aclk);
		wait_pause(16'h2);
		check(edges - mark >= 128 * 2 / 2 && edges - mark <= 131, 1);
		wr(8'h04, 32'h10, OK);
		wait_pause(16'h0);
		repeat (700) @(posedge aclk);
		check(pause_req, 0);
		mark = dones;
		wr(8'h08, 32'h200, OK);
		repeat (60) @(posedge aclk);
		check(dones - mark, 2);
		rd(8'h00, 32'h0002_8000, OK);
		mark = dones;
		wr(8'h08, 32'h200, OK);
		wr(8'h04, 32'h200, OK);
		repeat (60) @(posedge aclk);
		check(dones - mark, 1);
		rd(8'h00, 32'h0002_8000, OK);
		give_verdict();
	end
endmodule : tb_top
